/* File: verilog/ddr2_ctl_defs.vh */
// Constants for the DDR2 control-pin front end: commands, power states, mode fields.
// Notes on behaviour
// - Address and control inputs are taken where CK rises and its complement falls.
// - Read data is launched on both directions of the clock crossing.
// - CKE high enables internal clocks, input buffers and output drivers; low disables.
// - CKE low enters precharge power-down or self refresh if idle, else active power-down; the code enters self refresh on Refresh even with a bank open.
// - CKE is clock sampled for power-down entry, power-down exit and self-refresh entry.
// - Self-refresh exit follows CKE directly, without waiting for a clock crossing.
// - In power-down only the clock, ODT and CKE input buffers stay enabled.
// - In self refresh only the CKE input buffer stays enabled.
// - A crossing with chip select high carries no command.
// - The command is decoded from chip select, RAS, CAS and WE together.
// - ODT registered high switches on internal termination on the data path.
// - Narrow organisations terminate only DQ, data strobes, read strobes and DM.
// - Sixteen-bit organisation terminates all DQ, both strobe pairs and both masks.
// - With termination disabled in the extended mode register, ODT is ignored.
// - A write beat whose DM is sampled high is not stored.
// - DM is sampled on both edges of the data strobe, like write data.
// - In the eight-bit organisation a mode bit selects DM or the read strobe.
// - Bank inputs choose the bank of Active, Read, Write and single Precharge.
// - In a mode register set, bank inputs choose the mode or extended register.
// - Precharge with address bit 10 low closes one bank, high closes all.
// - With the read strobe enabled it mirrors the data strobe and masking is off.
`ifndef DDR2_CTL_DEFS_VH
`define DDR2_CTL_DEFS_VH

// Command codes as {ras_n, cas_n, we_n}
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_ACT 3'h3
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_BST 3'h6
`define CMD_NOP 3'h7

// Power states
`define PWR_ACTIVE 2'h0
`define PWR_PD_PRE 2'h1
`define PWR_PD_ACT 2'h2
`define PWR_SREF 2'h3
`define PWR_RST 2'h1

// Bank select values during a mode register set
`define BA_MR 2'h0
`define BA_EMR 2'h1

// Field positions in the extended mode register and command address words
`define EMR_RTT0 2
`define EMR_RTT1 6
`define EMR_RDQS 11
`define ADDR_AP 10

// Reset values
`define MR_RST 14'h0000
`define EMR_RST 14'h0000

`endif

/* File: verilog/pin_sync3.v */
// Three-stage input synchroniser with agreement filter for link pins.
module pin_sync3 #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // System
  input wire mclk,
  input wire nrst,
  // Pins and filtered result
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg hold_r;
      // First stage feeds only the second; a change counts once stages two and three agree
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
          hold_r <= RST_VAL[i];
        end else begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            hold_r <= s3_r;
          end
        end
      end
      assign dout[i] = hold_r;
    end
  endgenerate

endmodule

/* File: verilog/bank_tracker.v */
// Per-bank open-row tracker driven by decoded Active and Precharge commands.
module bank_tracker #(
  parameter NB = 4,
  parameter BW = 2
) (
  // System
  input wire mclk,
  input wire nrst,
  // Decoded commands
  input wire act,
  input wire pre,
  input wire pre_all,
  input wire [BW-1:0] bank,
  // State
  output wire [NB-1:0] open_mask,
  output wire any_open
);

  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_bank
      reg open_r;
      // Active opens the addressed bank, precharge closes one or all
      always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          open_r <= 1'b0;
        end else if (act && bank == b) begin
          open_r <= 1'b1;
        end else if (pre && (pre_all || bank == b)) begin
          open_r <= 1'b0;
        end
      end
      assign open_mask[b] = open_r;
    end
  endgenerate

  assign any_open = |open_mask;

endmodule

/* File: verilog/ddr2_control_pin_interface.v */
// DDR2 control-pin front end: command capture, CKE power states, ODT, DM and read launch.
`include "ddr2_ctl_defs.vh"
module ddr2_control_pin_interface #(
  parameter DQ_W = 8,
  parameter DM_W = 1,
  parameter ORG = 8
) (
  // System
  input wire mclk,
  input wire nrst,
  // Differential clock and clock enable
  input wire ck,
  input wire ck_n,
  input wire cke,
  // Command and address pins
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire [1:0] ba,
  input wire [13:0] addr,
  input wire odt,
  // Write data pins
  input wire dqs,
  input wire [DM_W-1:0] dm,
  input wire [DQ_W-1:0] dq_in,
  // Read data pins
  output wire [DQ_W-1:0] dq_out,
  output wire dq_oe,
  output wire dqs_out,
  output wire dqs_oe,
  output wire rdqs_out,
  output wire rdqs_oe,
  // Pad buffer and driver control
  output reg clk_en,
  output reg drv_en,
  output reg buf_en_ck,
  output reg buf_en_cke,
  output reg buf_en_odt,
  output reg buf_en_cmd,
  output reg buf_en_data,
  // Termination control
  output wire term_dq,
  output wire term_ldqs,
  output wire term_udqs,
  output wire term_rdqs,
  output wire term_ldm,
  output wire term_udm,
  // Decoded commands to the core
  output wire cmd_valid,
  output wire [2:0] cmd_code,
  output wire [1:0] cmd_bank,
  output wire [13:0] cmd_addr,
  output wire cmd_pre_all,
  output wire [3:0] bank_open,
  output wire [1:0] pwr_state,
  output wire [13:0] mode_reg,
  output wire [13:0] ext_mode_reg,
  output wire rdqs_mode,
  // Read launch from the core
  input wire rd_en,
  input wire [2*DQ_W-1:0] rd_word,
  // Write beats to the core
  input wire wr_window,
  output wire wr_beat_valid,
  output wire [DQ_W-1:0] wr_beat_data,
  output wire [DM_W-1:0] wr_beat_store
);

  localparam SW = 25 + DM_W + DQ_W;

  // All link pins pass one synchroniser bank
  wire [SW-1:0] raw;
  wire [SW-1:0] st;
  assign raw = {dq_in, dm, dqs, odt, addr, ba, we_n, cas_n, ras_n, cs_n, cke, ck_n, ck};

  pin_sync3 #(
    .W(SW),
    .RST_VAL({{(SW-7){1'b0}}, 7'h7A})
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(raw),
    .dout(st)
  );

  // Unpacked filtered pins
  wire s_ck = st[0];
  wire s_ck_n = st[1];
  wire s_cke = st[2];
  wire s_cs_n = st[3];
  wire [2:0] s_code = {st[4], st[5], st[6]};
  wire [1:0] s_ba = st[8:7];
  wire [13:0] s_addr = st[22:9];
  wire s_odt = st[23];
  wire s_dqs = st[24];
  wire [DM_W-1:0] s_dm = st[25 +: DM_W];
  wire [DQ_W-1:0] s_dq = st[25+DM_W +: DQ_W];

  // Crossing detection on the differential clock pair
  reg rx_prev_r;
  reg fx_prev_r;
  reg dqs_prev_r;
  wire rise_x = s_ck & ~s_ck_n;
  wire fall_x = ~s_ck & s_ck_n;
  wire ck_rise = rise_x & ~rx_prev_r;
  wire ck_fall = fall_x & ~fx_prev_r;
  wire dqs_edge = s_dqs ^ dqs_prev_r;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_prev_r <= 1'b0;
      fx_prev_r <= 1'b1; // Idle pins show the clock low, so no false fall after reset
      dqs_prev_r <= 1'b0;
    end else begin
      rx_prev_r <= rise_x;
      fx_prev_r <= fall_x;
      dqs_prev_r <= s_dqs;
    end
  end

  // Power state and last sampled CKE
  reg [1:0] pwr_r;
  reg [1:0] pwr_nxt;
  reg cke_q_r;
  wire any_open;
  wire sel = ~s_cs_n;
  wire is_ref = sel & (s_code == `CMD_REF);

  // Clock-sampled entry and exit, direct self-refresh exit
  always @* begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      `PWR_ACTIVE: begin
        if (ck_rise && cke_q_r && !s_cke) begin
          if (is_ref) begin
            pwr_nxt = `PWR_SREF;
          end else if (any_open) begin
            pwr_nxt = `PWR_PD_ACT;
          end else begin
            pwr_nxt = `PWR_PD_PRE;
          end
        end
      end
      `PWR_PD_PRE, `PWR_PD_ACT: begin
        if (ck_rise && s_cke) begin
          pwr_nxt = `PWR_ACTIVE;
        end
      end
      `PWR_SREF: begin
        if (s_cke) begin
          pwr_nxt = `PWR_ACTIVE;
        end
      end
      default: begin
        pwr_nxt = `PWR_RST;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pwr_r <= `PWR_RST;
      cke_q_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      if (ck_rise) begin
        cke_q_r <= s_cke;
      end else if (pwr_r == `PWR_SREF && s_cke) begin
        cke_q_r <= 1'b1;
      end
    end
  end

  // Buffer, driver and internal clock enables per power state
  always @* begin
    clk_en = 1'b0;
    drv_en = 1'b0;
    buf_en_ck = 1'b0;
    buf_en_cke = 1'b1;
    buf_en_odt = 1'b0;
    buf_en_cmd = 1'b0;
    buf_en_data = 1'b0;
    case (pwr_r)
      `PWR_ACTIVE: begin
        clk_en = 1'b1;
        drv_en = 1'b1;
        buf_en_ck = 1'b1;
        buf_en_odt = 1'b1;
        buf_en_cmd = 1'b1;
        buf_en_data = 1'b1;
      end
      `PWR_PD_PRE, `PWR_PD_ACT: begin
        buf_en_ck = 1'b1;
        buf_en_odt = 1'b1;
      end
      `PWR_SREF: begin
        buf_en_cke = 1'b1;
      end
      default: begin
        buf_en_cke = 1'b1;
      end
    endcase
  end

  // Command capture at a crossing with CKE high before and now
  reg cmd_valid_r;
  reg [2:0] cmd_code_r;
  reg [1:0] cmd_bank_r;
  reg [13:0] cmd_addr_r;
  reg [13:0] mr_r;
  reg [13:0] emr_r;
  wire take = ck_rise & cke_q_r & s_cke & sel & (pwr_r == `PWR_ACTIVE);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid_r <= 1'b0;
      cmd_code_r <= `CMD_NOP;
      cmd_bank_r <= 2'h0;
      cmd_addr_r <= 14'h0000;
      mr_r <= `MR_RST;
      emr_r <= `EMR_RST;
    end else begin
      cmd_valid_r <= take && (s_code != `CMD_NOP);
      if (take) begin
        cmd_code_r <= s_code;
        cmd_bank_r <= s_ba;
        cmd_addr_r <= s_addr;
        if (s_code == `CMD_MRS && s_ba == `BA_MR) begin
          mr_r <= s_addr;
        end
        if (s_code == `CMD_MRS && s_ba == `BA_EMR) begin
          emr_r <= s_addr;
        end
      end
    end
  end

  assign cmd_valid = cmd_valid_r;
  assign cmd_code = cmd_code_r;
  assign cmd_bank = cmd_bank_r;
  assign cmd_addr = cmd_addr_r;
  assign cmd_pre_all = cmd_addr_r[`ADDR_AP];
  assign mode_reg = mr_r;
  assign ext_mode_reg = emr_r;
  assign pwr_state = pwr_r;

  // Open-row bookkeeping for the power-down choice
  bank_tracker #(
    .NB(4),
    .BW(2)
  ) u_banks (
    .mclk(mclk),
    .nrst(nrst),
    .act(cmd_valid_r && cmd_code_r == `CMD_ACT),
    .pre(cmd_valid_r && cmd_code_r == `CMD_PRE),
    .pre_all(cmd_addr_r[`ADDR_AP]),
    .bank(cmd_bank_r),
    .open_mask(bank_open),
    .any_open(any_open)
  );

  // Termination: ODT registered at each rising crossing, dropped in self refresh
  reg odt_q_r;
  wire odt_cfg = emr_r[`EMR_RTT0] | emr_r[`EMR_RTT1];
  wire term_on = odt_q_r & odt_cfg;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      odt_q_r <= 1'b0;
    end else if (pwr_r == `PWR_SREF) begin
      odt_q_r <= 1'b0;
    end else if (ck_rise) begin
      odt_q_r <= s_odt;
    end
  end

  assign term_dq = term_on;
  assign term_ldqs = term_on;
  assign term_udqs = term_on & (ORG == 16);
  assign term_rdqs = term_on & (ORG == 8);
  assign term_ldm = term_on;
  assign term_udm = term_on & (ORG == 16);

  // Read strobe mode is only meaningful in the eight-bit organisation
  assign rdqs_mode = (ORG == 8) & emr_r[`EMR_RDQS];

  // Read launch: one half-word per clock crossing in each direction
  reg [DQ_W-1:0] dq_out_r;
  reg dq_oe_r;
  reg dqs_out_r;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dq_out_r <= {DQ_W{1'b0}};
      dq_oe_r <= 1'b0;
      dqs_out_r <= 1'b0;
    end else if (!drv_en) begin
      dq_oe_r <= 1'b0;
      dqs_out_r <= 1'b0;
    end else if (ck_rise) begin
      dq_out_r <= rd_word[DQ_W-1:0];
      dq_oe_r <= rd_en;
      dqs_out_r <= rd_en;
    end else if (ck_fall) begin
      dq_out_r <= rd_word[2*DQ_W-1:DQ_W];
      dq_oe_r <= rd_en;
      dqs_out_r <= 1'b0;
    end
  end

  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign dqs_out = dqs_out_r;
  assign dqs_oe = dq_oe_r;
  assign rdqs_out = dqs_out_r & rdqs_mode;
  assign rdqs_oe = dq_oe_r & rdqs_mode;

  // Write beats: data and mask taken on both strobe edges inside the write window
  reg wr_valid_r;
  reg [DQ_W-1:0] wr_data_r;
  reg [DM_W-1:0] wr_store_r;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_valid_r <= 1'b0;
      wr_data_r <= {DQ_W{1'b0}};
      wr_store_r <= {DM_W{1'b0}};
    end else begin
      wr_valid_r <= dqs_edge & wr_window & buf_en_data;
      if (dqs_edge && wr_window && buf_en_data) begin
        wr_data_r <= s_dq;
        if (rdqs_mode) begin
          wr_store_r <= {DM_W{1'b1}};
        end else begin
          wr_store_r <= ~s_dm;
        end
      end
    end
  end

  assign wr_beat_valid = wr_valid_r;
  assign wr_beat_data = wr_data_r;
  assign wr_beat_store = wr_store_r;

endmodule

/* File: testbench/ddr2_pin_checker.sv */
// Port-level assertions for the DDR2 control-pin front end.
module ddr2_pin_checker #(
  parameter DM_W = 1
) (
  // System
  input wire logic mclk,
  input wire logic nrst,
  // Power state and pad control
  input wire logic [1:0] pwr_state,
  input wire logic clk_en,
  input wire logic drv_en,
  input wire logic buf_en_ck,
  input wire logic buf_en_cke,
  input wire logic buf_en_odt,
  input wire logic buf_en_cmd,
  input wire logic buf_en_data,
  // Termination, commands, read and write
  input wire logic term_dq,
  input wire logic [13:0] ext_mode_reg,
  input wire logic cmd_valid,
  input wire logic dq_oe,
  input wire logic dqs_out,
  input wire logic rdqs_mode,
  input wire logic wr_beat_valid,
  input wire logic [DM_W-1:0] wr_beat_store
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Buffer enables follow the power state
  a_sref_buffers: assert property (pwr_state == 2'h3 |->
    buf_en_cke && !buf_en_ck && !buf_en_odt && !buf_en_cmd) else $error("sref buffers wrong");
  a_pd_buffers: assert property ((pwr_state == 2'h1 || pwr_state == 2'h2) |->
    buf_en_ck && buf_en_odt && buf_en_cke && !buf_en_cmd && !clk_en) else $error("pd buffers");
  a_active_enables: assert property (pwr_state == 2'h0 |->
    clk_en && drv_en && buf_en_cmd && buf_en_data) else $error("active enables low");
  a_drv_off_quiet: assert property (!drv_en [*2] |-> !dq_oe && !dqs_out)
    else $error("read drive while drivers off");
  // Commands only from the active state, one cycle each
  a_cmd_active: assert property (cmd_valid |-> $past(pwr_state) == 2'h0)
    else $error("command in low power");
  a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command pulse too long");
  // Termination gating
  a_odt_disabled: assert property ((!ext_mode_reg[2] && !ext_mode_reg[6]) [*2] |-> !term_dq)
    else $error("termination while disabled");
  a_sref_noterm: assert property ((pwr_state == 2'h3) [*2] |-> !term_dq)
    else $error("termination in self refresh");
  a_rdqs_nomask: assert property (wr_beat_valid && rdqs_mode |-> &wr_beat_store)
    else $error("mask active with read strobe");

  c_cmd: cover property (cmd_valid);
  c_sref: cover property (pwr_state == 2'h3);
  c_act_pd: cover property (pwr_state == 2'h2);
  c_rdqs_beat: cover property (wr_beat_valid && rdqs_mode);
endmodule

bind ddr2_control_pin_interface ddr2_pin_checker #(.DM_W(DM_W)) u_chk (.mclk(mclk),
  .nrst(nrst), .pwr_state(pwr_state), .clk_en(clk_en), .drv_en(drv_en),
  .buf_en_ck(buf_en_ck), .buf_en_cke(buf_en_cke), .buf_en_odt(buf_en_odt),
  .buf_en_cmd(buf_en_cmd), .buf_en_data(buf_en_data), .term_dq(term_dq),
  .ext_mode_reg(ext_mode_reg), .cmd_valid(cmd_valid), .dq_oe(dq_oe), .dqs_out(dqs_out),
  .rdqs_mode(rdqs_mode), .wr_beat_valid(wr_beat_valid), .wr_beat_store(wr_beat_store));

/* File: testbench/ddr2_ctrl_model.sv */
// Memory controller model: link clock, command pins, termination and write strobe.
module ddr2_ctrl_model (
  // Link clock, runs free through power-down as a controller keeps it
  output logic ck,
  output logic ck_n,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [13:0] addr,
  output logic odt,
  // Write data
  output logic dqs,
  output logic dm,
  output logic [7:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle pins: deselected, clock enable low
  initial begin
    ck = 0;
    {cke, ba, addr, odt, dqs, dm, dq_in} = '0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
  end
  always #80 ck = ~ck;
  assign ck_n = ~ck;

  // Set up half a period before the crossing, deselect half a period after
  task automatic send(input logic e, input logic s, input logic [2:0] c,
                      input logic [1:0] b, input logic [13:0] a, input logic o);
    @(negedge ck);
    cke = e;
    cs_n = s;
    {ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    odt = o;
    @(posedge ck);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = ~a;
  endtask

  // Clock enable change with no regard to the link clock
  task automatic cke_set(input logic v);
    cke = v;
  endtask

  // One write beat per strobe edge, data held 40 ns then inverted
  task automatic beat(input logic [7:0] d, input logic m);
    dq_in = d;
    dm = m;
    dqs = ~dqs;
    #40;
    dq_in = ~d;
    dm = ~m;
  endtask
endmodule

/* File: testbench/ddr2_control_pin_interface_tb.sv */
// Self-checking bench for the DDR2 control-pin front end.
`include "ddr2_ctl_defs.vh"
module ddr2_control_pin_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, rd_en = 0, wr_window = 0, odt_v = 0, cmd_valid, dq_oe;
  logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs, dm, term_dq, term_udqs, term_rdqs;
  logic buf_en_ck, buf_en_cmd, rdqs_mode, wr_beat_valid, wr_beat_store;
  logic clk_en, drv_en, buf_en_odt, buf_en_cke, buf_en_data, dqs_out, dqs_oe, rdqs_out, rdqs_oe;
  logic term_ldqs, term_ldm, term_udm, cmd_pre_all;
  logic [1:0] ba, pwr_state, cmd_bank;
  logic [2:0] cmd_code;
  logic [3:0] bank_open;
  logic [13:0] addr, ext_mode_reg, cmd_addr, mode_reg;
  logic [7:0] dq_in, dq_out, wr_beat_data;
  logic [15:0] rd_word = 0;
  int n_fail = 0, n_tests = 0;

  always #2 mclk = ~mclk;

  ddr2_ctrl_model u_ctl (.ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .dqs(dqs), .dm(dm),
    .dq_in(dq_in));

  ddr2_control_pin_interface DUT (.mclk(mclk), .nrst(nrst), .ck(ck), .ck_n(ck_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .dqs(dqs), .dm(dm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .rdqs_out(rdqs_out), .rdqs_oe(rdqs_oe), .clk_en(clk_en), .drv_en(drv_en),
    .buf_en_ck(buf_en_ck), .buf_en_cke(buf_en_cke), .buf_en_odt(buf_en_odt),
    .buf_en_cmd(buf_en_cmd), .buf_en_data(buf_en_data), .term_dq(term_dq),
    .term_ldqs(term_ldqs), .term_udqs(term_udqs), .term_rdqs(term_rdqs), .term_ldm(term_ldm),
    .term_udm(term_udm), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
    .cmd_addr(cmd_addr), .cmd_pre_all(cmd_pre_all), .bank_open(bank_open),
    .pwr_state(pwr_state), .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg),
    .rdqs_mode(rdqs_mode),
    .rd_en(rd_en), .rd_word(rd_word), .wr_window(wr_window), .wr_beat_valid(wr_beat_valid),
    .wr_beat_data(wr_beat_data), .wr_beat_store(wr_beat_store));

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (8) @(negedge mclk);
  endtask

  // One command with clock enable held high, then look for the decoded pulse
  task automatic cmd(input logic s, input logic [2:0] c, input logic [1:0] b,
                     input logic [13:0] a, input logic exp);
    logic seen;
    seen = 0;
    fork
      u_ctl.send(1'b1, s, c, b, a, odt_v);
      repeat (90) begin
        @(negedge mclk);
        if (cmd_valid === 1'b1) seen = 1;
      end
    join
    check(seen, exp);
    if (exp && !seen) end_of_test();
  endtask

  // One strobe edge, judge the stored beat
  task automatic beat_chk(input logic [7:0] d, input logic m, input logic st);
    logic seen;
    logic [7:0] gd;
    logic gs;
    seen = 0;
    fork
      u_ctl.beat(d, m);
      repeat (15) begin
        @(negedge mclk);
        if (wr_beat_valid === 1'b1) {seen, gd, gs} = {1'b1, wr_beat_data, wr_beat_store};
      end
    join
    check(gd, d);
    check(gs, st);
    if (!seen) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic t_wake;
    check(pwr_state, `PWR_PD_PRE);
    check(buf_en_ck, 1);
    repeat (2) u_ctl.send(1, 1, `CMD_NOP, 0, 0, 0);
    settle();
    check(pwr_state, `PWR_ACTIVE);
    check(buf_en_cmd, 1);
    check({clk_en, drv_en, buf_en_odt, buf_en_data}, 4'hf);
  endtask

  task automatic t_commands;
    cmd(0, `CMD_MRS, `BA_EMR, 14'h0004, 1);
    check(ext_mode_reg, 14'h0004);
    cmd(0, `CMD_MRS, `BA_MR, 14'h0123, 1);
    check(mode_reg, 14'h0123);
    check(ext_mode_reg, 14'h0004);
    cmd(0, `CMD_ACT, 2'h2, 0, 1);
    check(bank_open, 4'h4);
    cmd(0, `CMD_WR, 2'h2, 0, 1);
    check(cmd_bank, 2'h2);
    cmd(0, `CMD_RD, 2'h2, 0, 1);
    check(cmd_code, `CMD_RD);
    cmd(1, `CMD_ACT, 2'h1, 0, 0);
    check(bank_open, 4'h4);
    cmd(0, `CMD_NOP, 2'h1, 0, 0);
    cmd(0, `CMD_ACT, 2'h1, 0, 1);
    cmd(0, `CMD_PRE, 2'h1, 14'h0000, 1);
    check(bank_open, 4'h4);
    check(cmd_pre_all, 0);
    cmd(0, `CMD_PRE, 2'h0, 14'h0400, 1);
    check(bank_open, 4'h0);
    check({cmd_pre_all, cmd_addr}, 15'h4400);
  endtask

  task automatic t_odt;
    odt_v = 1;
    u_ctl.send(1, 1, `CMD_NOP, 0, 0, 1);
    settle();
    check(term_dq, 1);
    check({term_rdqs, term_udqs}, 2'h2);
    check({term_ldqs, term_ldm, term_udm}, 3'h6);
    cmd(0, `CMD_MRS, `BA_EMR, 14'h0000, 1);
    check(term_dq, 0);
    odt_v = 0;
  endtask

  task automatic t_power;
    cmd(0, `CMD_ACT, 2'h1, 0, 1);
    u_ctl.send(0, 1, `CMD_NOP, 0, 0, 0);
    settle();
    check(pwr_state, `PWR_PD_ACT);
    check({buf_en_ck, buf_en_cmd}, 2'h2);
    check({clk_en, drv_en, buf_en_odt, buf_en_cke, buf_en_data}, 5'h06);
    u_ctl.send(0, 0, `CMD_ACT, 2'h3, 0, 0);
    check(bank_open, 4'h2);
    u_ctl.send(1, 1, `CMD_NOP, 0, 0, 0);
    settle();
    check(pwr_state, `PWR_ACTIVE);
    cmd(0, `CMD_PRE, 2'h0, 14'h0400, 1);
    u_ctl.send(0, 0, `CMD_REF, 0, 0, 0);
    settle();
    check(pwr_state, `PWR_SREF);
    check({buf_en_ck, buf_en_cmd}, 2'h0);
    check({buf_en_odt, buf_en_cke, buf_en_data}, 3'h2);
    @(posedge ck);
    repeat (4) @(negedge mclk);
    u_ctl.cke_set(1);
    repeat (10) @(negedge mclk);
    check(pwr_state, `PWR_ACTIVE);
  endtask

  task automatic t_read;
    rd_en = 1;
    rd_word = 16'ha55a;
    @(posedge ck);
    settle();
    check({dq_oe, dq_out}, 16'h015a);
    check({dqs_out, dqs_oe, rdqs_out, rdqs_oe}, 4'hc);
    @(negedge ck);
    settle();
    check(dq_out, 8'ha5);
    check({dq_oe, dqs_out}, 2'h2);
    rd_en = 0;
  endtask

  task automatic t_write;
    wr_window = 1;
    beat_chk(8'h3c, 0, 1);
    beat_chk(8'hc3, 1, 0);
    cmd(0, `CMD_MRS, `BA_EMR, 14'h0800, 1);
    check(rdqs_mode, 1);
    rd_en = 1;
    @(posedge ck);
    settle();
    check({rdqs_out, rdqs_oe}, 2'h3);
    rd_en = 0;
    beat_chk(8'h5a, 1, 1);
    wr_window = 0;
  endtask

  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    nrst = 1;
    t_wake();
    t_commands();
    t_odt();
    t_power();
    t_read();
    t_write();
    end_of_test();
  end
endmodule
